/* tad_params.svh */
// Notes on behaviour
// - Each axis has a single-tap enable bit that resets to 0 and lets taps on that axis raise requests.
// - Each axis has a double-tap enable bit that resets to 0 and lets double taps on that axis raise requests.
// - A tap starts only when the axis acceleration magnitude is above the tap threshold.
// - The status interrupt-active flag resets to 0 and reads 1 once any enabled tap event occurred.
// - The status double-tap bit resets to 0 and reads 1 while any double-tap enable is set.
// - The status single-tap bit resets to 0 and reads 1 while any single-tap enable is set.
// - The status sign bit reads 0 for a positive tap and 1 for a negative tap.
// - Each axis has a status flag that resets to 0 and sets when an enabled tap event happened on that axis.
// - The 7-bit tap threshold resets to zero and sets the level a tap must exceed.
// - The 7-bit tap time limit resets to zero and bounds how long a tap may last.
// - The 8-bit tap latency resets to zero and sets the quiet time after a first tap.
// - The 7-bit wake threshold weighs 16, 32, 62 or 186 mg per step for 2, 4, 8 or 16 g.
// - The wake duration lasts eight times the field plus one sample periods.
`ifndef TAD_PARAMS_SVH
`define TAD_PARAMS_SVH
`define TAD_OFS_CFG    8'h38
`define TAD_OFS_STATUS 8'h39
`define TAD_OFS_THS    8'h3A
`define TAD_OFS_LIMIT  8'h3B
`define TAD_OFS_QUIET  8'h3C
`define TAD_OFS_WIN    8'h3D
`define TAD_OFS_WTHS   8'h3E
`define TAD_OFS_WDUR   8'h3F
`define TAD_RST_BYTE   8'h00
`define TAD_BIT_IA     6
`define TAD_BIT_DBL    5
`define TAD_BIT_SNG    4
`define TAD_BIT_SIGN   3
`define TAD_MG_2G      12'h010
`define TAD_MG_4G      12'h020
`define TAD_MG_8G      12'h03E
`define TAD_MG_16G     12'h0BA
`endif

/* tad_pkg.sv */
package tad_pkg;
  typedef enum logic [5:0] {
    TAD_IDLE   = 6'h01,
    TAD_ABOVE  = 6'h02,
    TAD_QUIET  = 6'h04,
    TAD_WINDOW = 6'h08,
    TAD_ABOVE2 = 6'h10,
    TAD_WAITLO = 6'h20
  } tad_det_e;

  typedef struct packed {
    tad_det_e   st;
    logic [7:0] cnt;
    logic       single;
    logic       dbl;
    logic       neg;
  } tad_det_s;

  typedef struct packed {
    logic [2:0] d_en;
    logic [2:0] s_en;
  } tad_cfg_s;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } tad_accel_s;

  typedef struct packed {
    tad_cfg_s    cfg;
    logic [6:0]  ths;
    logic [6:0]  lim;
    logic [7:0]  lat;
    logic [7:0]  win;
    logic [6:0]  wths;
    logic [7:0]  wdur;
    logic        ia;
    logic [2:0]  axis;
    logic        sign;
    logic        awake;
    logic [10:0] act_cnt;
    logic [7:0]  rdata;
  } tad_top_s;
endpackage : tad_pkg

/* tad_tap_axis.sv */
`timescale 1ns/10ps
`include "tad_params.svh"
module tad_tap_axis
  import tad_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic [7:0] accel,
  input  wire logic [6:0] ths,
  input  wire logic [6:0] lim,
  input  wire logic [7:0] lat,
  input  wire logic [7:0] win,
  output logic            single,
  output logic            dbl,
  output logic            neg
);
  tad_det_s   q_q;
  tad_det_s   q_d;
  logic [7:0] mag;
  logic       over;

  assign mag  = accel[7] ? 8'(-accel) : accel;
  assign over = mag > {1'b0, ths};

  always_comb begin
    q_d        = q_q;
    q_d.single = 1'b0;
    q_d.dbl    = 1'b0;
    if (tick) begin
      case (q_q.st)
        TAD_IDLE: begin
          if (over) begin
            q_d.st  = TAD_ABOVE;
            q_d.cnt = 8'h00;
            q_d.neg = accel[7];
          end
        end
        TAD_ABOVE, TAD_ABOVE2: begin
          if (!over) begin
            q_d.single = (q_q.st == TAD_ABOVE);
            q_d.dbl    = (q_q.st == TAD_ABOVE2);
            q_d.st     = (q_q.st == TAD_ABOVE) ? TAD_QUIET : TAD_IDLE;
            q_d.cnt    = 8'h00;
          end else if (q_q.cnt >= {1'b0, lim}) begin
            q_d.st = TAD_WAITLO;
          end else begin
            q_d.cnt = q_q.cnt + 8'h01;
          end
        end
        TAD_QUIET: begin
          // Taps during latency are ignored so ringing is not taken for a second tap
          if (q_q.cnt >= lat) begin
            q_d.st  = TAD_WINDOW;
            q_d.cnt = 8'h00;
          end else begin
            q_d.cnt = q_q.cnt + 8'h01;
          end
        end
        TAD_WINDOW: begin
          if (q_q.cnt >= win) begin
            q_d.st = TAD_IDLE;
          end else if (over) begin
            q_d.st  = TAD_ABOVE2;
            q_d.cnt = 8'h00;
            q_d.neg = accel[7];
          end else begin
            q_d.cnt = q_q.cnt + 8'h01;
          end
        end
        TAD_WAITLO: begin
          if (!over) begin
            q_d.st = TAD_IDLE;
          end
        end
        default: q_d.st = TAD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_q <= '{st: TAD_IDLE, default: '0};
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  assign single = q_q.single;
  assign dbl    = q_q.dbl;
  assign neg    = q_q.neg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  tap_start_over_a: assert property ((q_q.st == TAD_ABOVE) && ($past(q_q.st) == TAD_IDLE) |-> $past(over) && $past(tick))
    else $error("tap started without exceeding threshold");
  tap_in_limit_a: assert property (q_q.single |-> $past(q_q.cnt) <= {1'b0, $past(lim)})
    else $error("single tap longer than limit");
  second_in_window_a: assert property ((q_q.st == TAD_ABOVE2) && ($past(q_q.st) == TAD_WINDOW) |-> $past(q_q.cnt) < $past(win))
    else $error("second tap outside window");
  single_cov_c: cover property (q_q.single);
  double_cov_c: cover property (q_q.dbl);
endmodule : tad_tap_axis

/* tad_top.sv */
`timescale 1ns/10ps
`include "tad_params.svh"
module tad_top
  import tad_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sample_tick,
  input  wire tad_accel_s  accel,
  input  wire logic [1:0]  full_scale_range,
  input  wire logic        low_power,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             tap_irq,
  output logic             awake,
  output logic [11:0]      wake_ths_mg
);
  tad_top_s    q_q;
  tad_top_s    q_d;
  logic [2:0]  single_ev;
  logic [2:0]  double_ev;
  logic [2:0]  neg_ev;
  logic [2:0]  hit;
  logic [2:0]  axis_over;
  logic        any_over;
  logic        ev_sign;
  logic [7:0]  status_word;
  logic [7:0]  rd_mux;
  logic [11:0] lsb_mg;
  logic [10:0] dur_last;
  logic        wake_cond;
  logic [7:0]  ax [3];

  assign ax[0] = accel.x;
  assign ax[1] = accel.y;
  assign ax[2] = accel.z;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [7:0] mag;
    tad_tap_axis u_det (
      .mclk   (mclk),
      .rst    (rst),
      .ce     (ce),
      .tick   (sample_tick),
      .accel  (ax[i]),
      .ths    (q_q.ths),
      .lim    (q_q.lim),
      .lat    (q_q.lat),
      .win    (q_q.win),
      .single (single_ev[i]),
      .dbl    (double_ev[i]),
      .neg    (neg_ev[i])
    );
    assign hit[i]       = (single_ev[i] & q_q.cfg.s_en[i]) | (double_ev[i] & q_q.cfg.d_en[i]);
    assign mag          = ax[i][7] ? 8'(-ax[i]) : ax[i];
    assign axis_over[i] = mag > {1'b0, q_q.wths};
  end

  assign any_over = |axis_over;
  // Lowest axis wins the sign when two axes report in the same sample
  assign ev_sign  = hit[0] ? neg_ev[0] : (hit[1] ? neg_ev[1] : neg_ev[2]);

  assign status_word = {1'b0, q_q.ia, |q_q.cfg.d_en, |q_q.cfg.s_en, q_q.sign, q_q.axis[2], q_q.axis[1], q_q.axis[0]};

  always_comb begin
    case (full_scale_range)
      2'b00:   lsb_mg = `TAD_MG_2G;
      2'b01:   lsb_mg = `TAD_MG_4G;
      2'b10:   lsb_mg = `TAD_MG_8G;
      default: lsb_mg = `TAD_MG_16G;
    endcase
  end

  // Upper steps overflow 12 bits at 8 g and 16 g; the scaled value is only a reporting aid
  assign wake_ths_mg = 12'(lsb_mg * {5'h00, q_q.wths});
  assign dur_last    = {q_q.wdur, 3'b000};
  assign wake_cond   = q_q.awake ? !any_over : any_over;

  always_comb begin
    case (reg_addr)
      `TAD_OFS_CFG:    rd_mux = {2'b00, q_q.cfg.d_en[2], q_q.cfg.s_en[2], q_q.cfg.d_en[1], q_q.cfg.s_en[1],
                                 q_q.cfg.d_en[0], q_q.cfg.s_en[0]};
      `TAD_OFS_STATUS: rd_mux = status_word;
      `TAD_OFS_THS:    rd_mux = {1'b0, q_q.ths};
      `TAD_OFS_LIMIT:  rd_mux = {1'b0, q_q.lim};
      `TAD_OFS_QUIET:  rd_mux = q_q.lat;
      `TAD_OFS_WIN:    rd_mux = q_q.win;
      `TAD_OFS_WTHS:   rd_mux = {1'b0, q_q.wths};
      `TAD_OFS_WDUR:   rd_mux = q_q.wdur;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    q_d = q_q;
    if (reg_rd) begin
      q_d.rdata = rd_mux;
      if (reg_addr == `TAD_OFS_STATUS) begin
        q_d.ia   = 1'b0;
        q_d.axis = 3'b000;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        `TAD_OFS_CFG: begin
          q_d.cfg.s_en = {reg_wdata[4], reg_wdata[2], reg_wdata[0]};
          q_d.cfg.d_en = {reg_wdata[5], reg_wdata[3], reg_wdata[1]};
        end
        `TAD_OFS_THS:   q_d.ths  = reg_wdata[6:0];
        `TAD_OFS_LIMIT: q_d.lim  = reg_wdata[6:0];
        `TAD_OFS_QUIET: q_d.lat  = reg_wdata;
        `TAD_OFS_WIN:   q_d.win  = reg_wdata;
        `TAD_OFS_WTHS:  q_d.wths = reg_wdata[6:0];
        `TAD_OFS_WDUR:  q_d.wdur = reg_wdata;
        default: ;
      endcase
    end
    // Events land after the read clear so a tap in the read cycle is kept
    if (|hit) begin
      q_d.ia   = 1'b1;
      q_d.axis = q_d.axis | hit;
      q_d.sign = ev_sign;
    end
    if (!low_power) begin
      q_d.awake   = 1'b1;
      q_d.act_cnt = 11'h000;
    end else if (sample_tick) begin
      if (!wake_cond) begin
        q_d.act_cnt = 11'h000;
      end else if (q_q.act_cnt >= dur_last) begin
        q_d.awake   = !q_q.awake;
        q_d.act_cnt = 11'h000;
      end else begin
        q_d.act_cnt = q_q.act_cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_q       <= '0;
      q_q.awake <= 1'b1;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  assign reg_rdata = q_q.rdata;
  assign tap_irq   = q_q.ia;
  assign awake     = q_q.awake;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sgl_en_reset_a: assert property ($fell(rst) |-> q_q.cfg.s_en == 3'b000)
    else $error("single enables not cleared by reset");
  dbl_en_reset_a: assert property ($fell(rst) |-> q_q.cfg.d_en == 3'b000)
    else $error("double enables not cleared by reset");
  irq_active_set_a: assert property (ce && (|hit) |=> q_q.ia && tap_irq)
    else $error("tap event did not set interrupt active");
  read_clear_a: assert property (ce && reg_rd && reg_addr == `TAD_OFS_STATUS && !(|hit) |=> !q_q.ia)
    else $error("status read did not clear interrupt active");
  dbl_flag_en_a: assert property (ce && reg_wr && reg_addr == `TAD_OFS_CFG && reg_wdata[1] && !reg_rd
                                  ##1 ce && reg_rd && reg_addr == `TAD_OFS_STATUS && !reg_wr |=> reg_rdata[`TAD_BIT_DBL])
    else $error("double flag not set by enable");
  sng_flag_en_a: assert property (ce && reg_wr && reg_addr == `TAD_OFS_CFG && reg_wdata[0] && !reg_rd
                                  ##1 ce && reg_rd && reg_addr == `TAD_OFS_STATUS && !reg_wr |=> reg_rdata[`TAD_BIT_SNG])
    else $error("single flag not set by enable");
  sign_capture_a: assert property (ce && hit[0] |=> q_q.sign == $past(neg_ev[0]))
    else $error("sign not taken from tapped axis");
  axis_flag_set_a: assert property (ce && (|hit) |=> (q_q.axis & $past(hit)) == $past(hit))
    else $error("axis flag not set");
  times_reset_a: assert property ($fell(rst) |-> q_q.ths == 7'h00 && q_q.lim == 7'h00 && q_q.lat == 8'h00)
    else $error("tap timing fields not cleared by reset");
  wake_scale_a: assert property (full_scale_range == 2'b01 |-> wake_ths_mg == 12'({q_q.wths, 5'h00}))
    else $error("wake threshold scale wrong at 4 g");
  wake_toggle_a: assert property (ce && low_power && sample_tick && wake_cond && q_q.act_cnt == dur_last
                                  |=> awake != $past(awake))
    else $error("wake state did not switch at duration end");
  wake_hold_a: assert property (ce && low_power && sample_tick && q_q.act_cnt < dur_last |=> awake == $past(awake))
    else $error("wake state switched early");
  irq_cov_c: cover property (ce && (|hit));
  sleep_cov_c: cover property ($fell(awake));
  wake_cov_c: cover property ($rose(awake) && low_power);
endmodule : tad_top

/* tad_host.sv */
`timescale 1ns/10ps
module tad_host (
  input  wire logic       mclk,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    // Released data must not look valid, so show its inverse
    reg_wdata = ~d;
  endtask : wr

  // Write then read on the very next edge, to reach the back-to-back case
  task automatic wr_rd(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = wa;
    reg_wdata = wd;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~wd;
    reg_addr = ra;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : wr_rd

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : tad_host

/* tad_top_tb.sv */
`timescale 1ns/10ps
module tad_top_tb;
  import tad_pkg::*;
  logic        mclk, rst, ce, sample_tick, low_power, reg_wr, reg_rd, tap_irq, awake;
  tad_accel_s  accel;
  logic [1:0]  full_scale_range;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic [11:0] wake_ths_mg;
  int          bad_count, checks;
  localparam logic [7:0] RA[9] = '{8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40};
  localparam logic [7:0] RW[9] = '{8'hFF, 8'hFF, 8'hFF, 8'h85, 8'hA5, 8'h5A, 8'hFF, 8'h03, 8'h77};
  localparam logic [7:0] RE[9] = '{8'h3F, 8'h30, 8'h7F, 8'h05, 8'hA5, 8'h5A, 8'h7F, 8'h03, 8'h00};
  localparam logic [11:0] MG[4] = '{12'h020, 12'h040, 12'h07C, 12'h174};

  tad_top tad_top_inst (.mclk(mclk), .rst(rst), .ce(ce), .sample_tick(sample_tick), .accel(accel),
    .full_scale_range(full_scale_range), .low_power(low_power), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tap_irq(tap_irq), .awake(awake),
    .wake_ths_mg(wake_ths_mg));
  tad_host tad_host_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One sample period: a tick with the given x and z, then settle time for the status path
  task automatic smp(input logic [7:0] ax, input logic [7:0] az);
    @(posedge mclk);
    #1;
    accel = '{x: ax, y: 8'h00, z: az};
    sample_tick = 1'b1;
    @(posedge mclk);
    #1;
    sample_tick = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : smp

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sample_tick = 1'b0;
    accel = '0;
    full_scale_range = 2'b00;
    low_power = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      tad_host_inst.rd(RA[i], rv);
      chk("reset value", 12'h000, {4'h0, rv});
    end
    chk("irq at reset", 12'h000, {11'h0, tap_irq});
    chk("awake at reset", 12'h001, {11'h0, awake});
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      tad_host_inst.wr(RA[i], RW[i]);
      tad_host_inst.rd(RA[i], rv);
      chk("register row", {4'h0, RE[i]}, {4'h0, rv});
    end
    $display("test register rows done");
    // Strobes without clock enable must leave the threshold alone
    ce = 1'b0;
    tad_host_inst.wr(8'h3A, 8'h11);
    ce = 1'b1;
    tad_host_inst.rd(8'h3A, rv);
    chk("frozen write", 12'h07F, {4'h0, rv});
    // Status read straight after the enable write must already show both enables
    tad_host_inst.wr_rd(8'h38, 8'h03, 8'h39, rv);
    chk("enable flags", 12'h030, {4'h0, rv});
    $display("test enable flags done");
    tad_host_inst.wr(8'h3E, 8'h02);
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk);
      #1;
      full_scale_range = f[1:0];
      #1;
      chk("wake mg", MG[f], wake_ths_mg);
    end
    $display("test wake scale done");
    tad_host_inst.wr(8'h38, 8'h01);
    tad_host_inst.wr(8'h3A, 8'h0A);
    tad_host_inst.wr(8'h3B, 8'h02);
    smp(8'h0A, 8'h00);
    smp(8'h00, 8'h00);
    chk("at threshold", 12'h000, {11'h0, tap_irq});
    for (int i = 0; i < 5; i++) smp(8'hEC, 8'h00);
    smp(8'h00, 8'h00);
    chk("too long", 12'h000, {11'h0, tap_irq});
    smp(8'hEC, 8'h00);
    smp(8'hEC, 8'h00);
    smp(8'h00, 8'h00);
    chk("single irq", 12'h001, {11'h0, tap_irq});
    tad_host_inst.rd(8'h39, rv);
    chk("single status", 12'h059, {4'h0, rv});
    tad_host_inst.rd(8'h39, rv);
    chk("status cleared", 12'h018, {4'h0, rv});
    $display("test single tap done");
    tad_host_inst.wr(8'h38, 8'h20);
    tad_host_inst.wr(8'h3C, 8'h01);
    tad_host_inst.wr(8'h3D, 8'h04);
    smp(8'h00, 8'h14);
    for (int i = 0; i < 3; i++) smp(8'h00, 8'h00);
    chk("no single", 12'h000, {11'h0, tap_irq});
    smp(8'h00, 8'h14);
    smp(8'h00, 8'h00);
    tad_host_inst.rd(8'h39, rv);
    chk("double status", 12'h064, {4'h0, rv});
    $display("test double tap done");
    // Duration 1 means nine qualifying samples before switching
    tad_host_inst.wr(8'h3E, 8'h05);
    tad_host_inst.wr(8'h3F, 8'h01);
    low_power = 1'b1;
    for (int i = 0; i < 8; i++) smp(8'h00, 8'h00);
    chk("still awake", 12'h001, {11'h0, awake});
    smp(8'h00, 8'h00);
    chk("asleep", 12'h000, {11'h0, awake});
    for (int i = 0; i < 8; i++) smp(8'h06, 8'h00);
    chk("still asleep", 12'h000, {11'h0, awake});
    smp(8'h06, 8'h00);
    chk("woken", 12'h001, {11'h0, awake});
    $display("test wake duration done");
    // Mid-run reset with no interrupt pending and with programmed fields
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("irq after reset", 12'h000, {11'h0, tap_irq});
    chk("awake after reset", 12'h001, {11'h0, awake});
    tad_host_inst.rd(8'h38, rv);
    chk("cfg after reset", 12'h000, {4'h0, rv});
    tad_host_inst.rd(8'h3A, rv);
    chk("ths after reset", 12'h000, {4'h0, rv});
    $display("test mid reset done");
    end_sim();
  end
endmodule : tad_top_tb
